// [hw/input_terminal_functions.sv]
// Input terminal functions: parameter lock, analog source select, trip clear
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "input_terminal_functions_map.svh"

// How it works
// [RQ1] Lock input rejects edits, setpoint per scope
// [RQ2] Lock released, keypad edits accepted again
// [RQ3] Code 15 slot is the lock
// [RQ4] Scope bit includes or excludes setpoint
// [RQ5] Operator lock bit locks without terminal
// [RQ6] Code 16 slot asserted selects current
// [RQ7] Select low uses voltage reference
// [RQ8] Analog reference only when source 01
// [RQ9] Clear pulse on-off cancels trip state
// [RQ10] Source holds clear at least 12 ms
// [RQ11] Alarm drops within 30 ms of onset
// [RQ12] Code 18 slot: output off, trip cleared
// [RQ13] Clear while running lets motor coast
// [RQ14] Clear input accepted only non-inverted
// [RQ15] Power-up runs the same reset sequence
// [RQ16] Stop key resets only with alarm
// [RQ17] Clear held 4 s at power-up: comm error
// [RQ18] Run still active resumes drive at once
// [RQ19] Stop key honoured briefly after power-up
// [RQ20] Inputs synchronised, millisecond tick counts time
module input_terminal_functions
  import input_terminal_functions_pkg::*;
#(
  parameter int unsigned MS_CYCLES     = `ITF_MS_CYCLES,
  parameter int unsigned PWRUP_HOLD_MS = `ITF_PWRUP_HOLD_MS,
  parameter int unsigned KEY_WINDOW_MS = `ITF_KEY_WINDOW_MS
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Terminals and operator
  input  wire logic [5:0]  terminal_in,
  input  wire logic        stop_key,
  input  wire logic        remote_attached,
  input  wire logic        any_key,
  input  wire logic        run_cmd,
  input  wire logic        fault_event,
  input  wire logic        edit_req,
  input  wire logic        edit_is_setpoint,
  // Drive status
  output logic             motor_en,
  output logic             alarm_out,
  output logic             trip_state,
  output logic             comm_error,
  output logic             use_current_ref,
  output logic             analog_ref_en,
  output logic             edit_accept,
  output logic             edit_reject,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  initial begin
    if (MS_CYCLES < 2 || MS_CYCLES > 16383 || PWRUP_HOLD_MS > 8191 ||
        KEY_WINDOW_MS > 8191 || KEY_WINDOW_MS < 1) begin
      $error("input_terminal_functions: unsupported timing parameters");
    end
  end

  localparam logic [13:0] MS_LAST    = 14'(MS_CYCLES - 1);
  localparam logic [12:0] RST_MIN    = 13'(`ITF_RESET_MIN_MS);
  localparam logic [12:0] CLR_MS     = 13'(`ITF_ALARM_CLR_MS);
  localparam logic [12:0] PWRUP_HOLD = 13'(PWRUP_HOLD_MS);
  localparam logic [12:0] KEY_WIN    = 13'(KEY_WINDOW_MS);

  itf_state_t q;
  itf_state_t d;

  // Input level of any slot carrying a given function, with polarity when allowed
  function automatic logic func_level(input logic [31:0] funcs, input logic [5:0] pol,
                                      input logic [5:0] lvl, input logic [7:0] code,
                                      input logic allow_inv);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `ITF_SLOTS; i++) begin
      if (8'(funcs[i*5 +: 5]) == code) begin
        hit = hit | (lvl[i] ^ (pol[i] & allow_inv));
      end
    end
    return hit;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic lock_in;
  logic asel_in;
  logic tclr_in;
  logic locked;
  logic [31:0] wr_val;
  logic [31:0] rd_val;

  always_comb begin
    d = q;
    // [RQ20] Two-flop synchroniser
    d.term_s1 = terminal_in;
    d.term_s2 = q.term_s1;
    // [RQ20] Millisecond tick
    d.tick = 1'b0;
    if (q.tick_cnt == MS_LAST) begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 14'h0001;
    end

    // [RQ3] Lock slot decode
    lock_in = func_level(q.slot_func, q.slot_pol, q.term_s2, `ITF_FUNC_LOCK, 1'b1);
    // [RQ6] Select slot decode
    asel_in = func_level(q.slot_func, q.slot_pol, q.term_s2, `ITF_FUNC_ASEL, 1'b1);
    // [RQ14] Polarity ignored for trip clear
    tclr_in = func_level(q.slot_func, q.slot_pol, q.term_s2, `ITF_FUNC_TCLR, 1'b0);

    // [RQ5] Operator lock needs no terminal
    locked = lock_in | q.op_lock;
    // [RQ1] Reject locked edits; [RQ4] scope bit covers setpoint
    d.edit_ok  = 1'b0;
    d.edit_rej = 1'b0;
    if (edit_req) begin
      // [RQ2] Unlocked edits accepted
      if (locked && (!edit_is_setpoint || q.scope)) begin
        d.edit_rej = 1'b1;
      end else begin
        d.edit_ok = 1'b1;
      end
    end

    // [RQ8] Analog only when source is 01; [RQ7] low picks voltage
    d.analog_en   = (q.fsrc == `ITF_FSRC_ANALOG);
    d.use_current = asel_in & (q.fsrc == `ITF_FSRC_ANALOG);

    // [RQ19] Stop key window after power-up
    if (q.tick && q.uptime_ms != KEY_WIN) begin
      d.uptime_ms = q.uptime_ms + 13'h0001;
    end
    d.key_window = (q.uptime_ms != KEY_WIN);

    if (fault_event) begin
      d.tripped = 1'b1;
      d.alarm   = 1'b1;
    end

    unique case (q.tc_state)
      TC_PWRUP: begin
        d.motor_en = 1'b0;
        // [RQ15] Power-up reset as a clear pulse
        // Wait for a tick so the synchroniser holds real levels
        if (q.tick && !tclr_in) begin
          d.tc_state = TC_IDLE;
          d.tripped  = fault_event;
          d.alarm    = fault_event;
        end else if (q.tick) begin
          if (q.ms_cnt != PWRUP_HOLD) begin
            d.ms_cnt = q.ms_cnt + 13'h0001;
          end else begin
            // [RQ17] Comm error only, no trip
            d.comm_err = 1'b1;
          end
        end
      end
      TC_IDLE: begin
        d.ms_cnt = '0;
        d.alarm_clr_done = 1'b0;
        // [RQ18] Run with no trip drives at once
        d.motor_en = run_cmd & ~q.tripped & ~fault_event;
        if (tclr_in) begin
          // [RQ12] [RQ13] Output off, motor coasts
          d.motor_en = 1'b0;
          d.tc_state = TC_HELD;
        end else if (stop_key && q.alarm && (q.key_window || !remote_attached)) begin
          // [RQ16] Key resets only with alarm
          d.tripped = fault_event;
          d.alarm   = fault_event;
        end
      end
      TC_HELD: begin
        d.motor_en = 1'b0;
        if (q.tick && q.ms_cnt != 13'h1FFF) begin
          d.ms_cnt = q.ms_cnt + 13'h0001;
        end
        // [RQ11] Alarm drops by 30 ms
        if (q.tick && q.ms_cnt >= RST_MIN && !q.alarm_clr_done) begin
          d.alarm = fault_event;
          d.alarm_clr_done = 1'b1;
        end
        if (q.tick && q.ms_cnt + 13'h0001 >= CLR_MS && !q.alarm_clr_done) begin
          d.alarm = fault_event;
          d.alarm_clr_done = 1'b1;
        end
        if (!tclr_in) begin
          d.tc_state = TC_IDLE;
          // [RQ10] [RQ9] Pulse long enough cancels trip
          if (q.ms_cnt >= RST_MIN) begin
            d.tripped = fault_event;
            d.alarm   = fault_event;
          end
        end
      end
      default: begin
        d.tc_state = TC_IDLE;
      end
    endcase

    // [RQ17] Clear indication after release and a key
    if (q.comm_err && !tclr_in && any_key) begin
      d.comm_err = 1'b0;
    end

    // AXI4-Lite write channel
    d.awready = 1'b0;
    d.wready  = 1'b0;
    if (!q.aw_got && s_axi_awvalid && !q.awready) begin
      d.awready = 1'b1;
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (!q.w_got && s_axi_wvalid && !q.wready) begin
      d.wready = 1'b1;
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    wr_val = 32'h0000_0000;
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = 2'b00;
      unique case (q.aw_addr)
        `ITF_OFF_SLOT_FUNC: begin
          d.slot_func = merge(q.slot_func, q.w_data, q.w_strb);
        end
        `ITF_OFF_SLOT_POL: begin
          wr_val = merge({26'h0, q.slot_pol}, q.w_data, q.w_strb);
          d.slot_pol = wr_val[5:0];
        end
        `ITF_OFF_SETTINGS: begin
          wr_val = merge({28'h0, q.fsrc, q.op_lock, q.scope}, q.w_data, q.w_strb);
          d.scope   = wr_val[`ITF_SET_SCOPE_BIT];
          d.op_lock = wr_val[`ITF_SET_OPLOCK_BIT];
          d.fsrc    = wr_val[`ITF_SET_FSRC_LSB +: 2];
        end
        default: begin
          d.bresp = 2'b10;
        end
      endcase
    end

    // AXI4-Lite read channel
    d.arready = 1'b0;
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    rd_val = 32'h0000_0000;
    if (s_axi_arvalid && !q.arready && !q.rvalid) begin
      d.arready = 1'b1;
      d.rvalid  = 1'b1;
      d.rresp   = 2'b00;
      unique case (s_axi_araddr)
        `ITF_OFF_SLOT_FUNC: rd_val = q.slot_func;
        `ITF_OFF_SLOT_POL:  rd_val = {26'h0, q.slot_pol};
        `ITF_OFF_SETTINGS:  rd_val = {28'h0, q.fsrc, q.op_lock, q.scope};
        `ITF_OFF_EDIT:      rd_val = {30'h0, q.edit_rej, q.edit_ok};
        `ITF_OFF_STATUS: begin
          rd_val = {24'h0, q.key_window, q.comm_err, q.use_current, q.analog_en,
                    q.motor_en, q.alarm, q.tripped, locked};
        end
        `ITF_OFF_CONTROL:   rd_val = {19'h0, q.ms_cnt};
        default: begin
          d.rresp = 2'b10;
        end
      endcase
      d.rdata = rd_val;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.slot_func <= `ITF_FUNC_RESET;
      q.tc_state  <= TC_PWRUP;
    end else begin
      q <= d;
    end
  end

  assign motor_en        = q.motor_en;
  assign alarm_out       = q.alarm;
  assign trip_state      = q.tripped;
  assign comm_error      = q.comm_err;
  assign use_current_ref = q.use_current;
  assign analog_ref_en   = q.analog_en;
  assign edit_accept     = q.edit_ok;
  assign edit_reject     = q.edit_rej;
  assign s_axi_awready   = q.awready;
  assign s_axi_wready    = q.wready;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_arready   = q.arready;
  assign s_axi_rdata     = q.rdata;
  assign s_axi_rresp     = q.rresp;
  assign s_axi_rvalid    = q.rvalid;

endmodule
`default_nettype wire

// [hw/input_terminal_functions_map.svh]
// Register offsets, fields, reset values and timing counts for the input terminal block
`ifndef INPUT_TERMINAL_FUNCTIONS_MAP_SVH
`define INPUT_TERMINAL_FUNCTIONS_MAP_SVH
`define ITF_CLK_HZ          10000000
`define ITF_MS_CYCLES       (`ITF_CLK_HZ / 1000)
`define ITF_RESET_MIN_MS    12
`define ITF_ALARM_CLR_MS    30
`define ITF_PWRUP_HOLD_MS   4000
`define ITF_KEY_WINDOW_MS   3000
`define ITF_FUNC_LOCK       8'h0F
`define ITF_FUNC_ASEL       8'h10
`define ITF_FUNC_TCLR       8'h12
`define ITF_FSRC_ANALOG     2'h1
`define ITF_SLOTS           6
`define ITF_OFF_SLOT_FUNC   8'h00
`define ITF_OFF_SLOT_POL    8'h04
`define ITF_OFF_SETTINGS    8'h08
`define ITF_OFF_EDIT        8'h0C
`define ITF_OFF_STATUS      8'h10
`define ITF_OFF_CONTROL     8'h14
`define ITF_SET_SCOPE_BIT   0
`define ITF_SET_OPLOCK_BIT  1
`define ITF_SET_FSRC_LSB    2
// Last slot defaults to trip clear so power-up hold detection is reachable
`define ITF_FUNC_RESET      32'h2400_0000
`endif

// [hw/input_terminal_functions_pkg.sv]
// Types shared by the input terminal block
package input_terminal_functions_pkg;
  typedef enum logic [1:0] {
    TC_IDLE  = 2'b00,
    TC_HELD  = 2'b01,
    TC_PWRUP = 2'b10
  } tclr_state_t;

  typedef struct packed {
    logic [5:0]  term_s1;
    logic [5:0]  term_s2;
    logic [31:0] slot_func;
    logic [5:0]  slot_pol;
    logic        scope;
    logic        op_lock;
    logic [1:0]  fsrc;
    logic [13:0] tick_cnt;
    logic        tick;
    tclr_state_t tc_state;
    logic [12:0] ms_cnt;
    logic        tripped;
    logic        alarm;
    logic        alarm_clr_done;
    logic        motor_en;
    logic        comm_err;
    logic [12:0] uptime_ms;
    logic        key_window;
    logic        edit_ok;
    logic        edit_rej;
    logic        use_current;
    logic        analog_en;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
  } itf_state_t;
endpackage

// [dv/input_terminal_functions_checker.sv]
// Port-level assertions for the input terminal block
`timescale 1ns/1ps
`default_nettype none
module input_terminal_functions_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Operator, fault and edit inputs
  input wire logic stop_key,
  input wire logic remote_attached,
  input wire logic fault_event,
  input wire logic edit_req,
  // Drive status
  input wire logic motor_en,
  input wire logic alarm_out,
  input wire logic trip_state,
  input wire logic edit_accept,
  input wire logic edit_reject,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_edit_answered: assert property (
    edit_req |=> edit_accept ^ edit_reject) else $error("edit not answered once");
  a_edit_quiet: assert property (
    !edit_req |=> !edit_accept && !edit_reject) else $error("edit result without request");
  a_fault_trips: assert property (
    fault_event |=> trip_state && alarm_out) else $error("fault did not trip");
  a_trip_no_drive: assert property (
    trip_state && $past(trip_state) |-> !motor_en) else $error("drive on while tripped");
  a_reset_outputs: assert property (
    $fell(sys_rst) |-> !motor_en && !alarm_out && !trip_state) else $error("outputs after reset");
  a_stop_clears: assert property (
    stop_key && alarm_out && !remote_attached && !fault_event |-> ##[1:4] !alarm_out)
    else $error("stop key did not clear alarm");
  a_read_answer: assert property (
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("read not answered");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
  c_reject: cover property (edit_reject);
  c_trip: cover property (fault_event ##1 trip_state);
  c_alarm_drop: cover property ($fell(alarm_out));
endmodule
bind input_terminal_functions input_terminal_functions_checker chk_inst (
  .ref_clk, .sys_rst, .stop_key, .remote_attached, .fault_event, .edit_req,
  .motor_en, .alarm_out, .trip_state, .edit_accept, .edit_reject,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [dv/contact_bank.sv]
// Model of the external switch contacts on the terminals
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
  // Clock
  input  wire logic       ref_clk,
  // Requested contacts and speed
  input  wire logic [5:0] closed,
  input  wire logic       slow,
  // Terminal levels
  output logic      [5:0] terminal_in
);
  logic [5:0] stage_q;
  // contact kept closed as long as asked
  always_ff @(posedge ref_clk) begin
    stage_q <= closed;
    terminal_in <= slow ? stage_q : closed;
  end
endmodule
`default_nettype wire

// [dv/input_terminal_functions_test.sv]
// Self-checking bench for the input terminal block
`timescale 1ns/1ps
`default_nettype none
module input_terminal_functions_test;
  localparam int MS = 4;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  closed = 6'h00;
  logic [5:0]  term;
  logic        slow = 1'b0, stop_key = 1'b0, remote = 1'b0, run_cmd = 1'b1;
  logic        fault = 1'b0, edit_req = 1'b0, edit_sp = 1'b0;
  logic        motor_en, alarm_out, trip_state, acc, rej, aen, cur, comm;
  logic        any_k = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  int          n_fail = 0, compares = 0, n;
  always #50 ref_clk = ~ref_clk;
  contact_bank contact_bank_inst (.ref_clk(ref_clk), .closed(closed), .slow(slow),
    .terminal_in(term));
  input_terminal_functions #(.MS_CYCLES(MS), .PWRUP_HOLD_MS(5), .KEY_WINDOW_MS(5))
  input_terminal_functions_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .terminal_in(term),
    .stop_key(stop_key), .remote_attached(remote), .any_key(any_k), .run_cmd(run_cmd),
    .fault_event(fault), .edit_req(edit_req), .edit_is_setpoint(edit_sp),
    .motor_en(motor_en), .alarm_out(alarm_out), .trip_state(trip_state), .comm_error(comm),
    .use_current_ref(cur), .analog_ref_en(aen), .edit_accept(acc), .edit_reject(rej),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic w(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!rvalid);
    arvalid <= 1'b0;
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic ed(input logic sp, input logic [1:0] exp);
    @(posedge ref_clk);
    edit_req <= 1'b1;
    edit_sp <= sp;
    @(posedge ref_clk);
    edit_req <= 1'b0;
    @(posedge ref_clk);
    chk("edit result", exp, {rej, acc});
  endtask
  // Sync is two cycles, so six covers contact, sync and register
  task automatic tm(input logic [5:0] v);
    closed <= v;
    w(6);
  endtask
  task automatic ft;
    @(posedge ref_clk);
    fault <= 1'b1;
    @(posedge ref_clk);
    fault <= 1'b0;
    w(3);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    w(2);
    sys_rst <= 1'b0;
    w(8);
    chk("drive after power-up", 1, motor_en);
    axw(8'h00, 32'h0000_4A0F);
    axr(8'h00);
    chk("slot functions", 32'h0000_4A0F, d);
    axr(8'h40);
    chk("unmapped resp", 2'h2, r);
    tm(6'h01);
    ed(1'b0, 2'h2);
    ed(1'b1, 2'h1);
    axw(8'h08, 32'h1);
    ed(1'b1, 2'h2);
    axw(8'h08, 32'h0);
    tm(6'h00);
    ed(1'b0, 2'h1);
    axw(8'h08, 32'h2);
    ed(1'b0, 2'h2);
    slow <= 1'b1;
    axw(8'h08, 32'h4);
    w(2);
    chk("analog enable", 1, aen);
    tm(6'h02);
    chk("current select", 1, cur);
    tm(6'h00);
    chk("voltage select", 0, cur);
    axw(8'h08, 32'h0);
    w(2);
    chk("analog disable", 0, aen);
    slow <= 1'b0;
    ft();
    chk("trip alarm drive", 3'h6, {trip_state, alarm_out, motor_en});
    tm(6'h04);
    w(14);
    tm(6'h00);
    chk("trip after short clear", 1, trip_state);
    tm(6'h04);
    chk("drive during clear", 0, motor_en);
    n = 0;
    while (alarm_out === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk("alarm clear in time", 1, n + 6 <= 30 * MS);
    w(MS);
    chk("drive while held", 0, motor_en);
    tm(6'h00);
    chk("trip after clear", 0, trip_state);
    chk("drive resumes", 1, motor_en);
    axw(8'h04, 32'h4);
    w(6);
    chk("inverted clear ignored", 1, motor_en);
    axw(8'h04, 32'h0);
    ft();
    remote <= 1'b1;
    stop_key <= 1'b1;
    w(6);
    stop_key <= 1'b0;
    chk("stop with remote", 1, alarm_out);
    remote <= 1'b0;
    stop_key <= 1'b1;
    w(6);
    stop_key <= 1'b0;
    chk("stop with alarm", 0, alarm_out);
    // Power-up with the default clear slot held closed
    tm(6'h20);
    sys_rst <= 1'b1;
    w(2);
    sys_rst <= 1'b0;
    w(40);
    chk("comm error on held clear", 1, comm);
    chk("no trip on held clear", 0, trip_state);
    chk("no drive while held", 0, motor_en);
    tm(6'h00);
    chk("comm error before key", 1, comm);
    any_k <= 1'b1;
    w(2);
    any_k <= 1'b0;
    chk("comm error cleared", 0, comm);
    chk("drive after power-up clear", 1, motor_en);
    w(2);
    end_of_test();
  end
endmodule
`default_nettype wire
